// file: shared/ocm_pkg.sv
// Package for the overlay character memory and field select block.
// Assumes one 10 MHz core clock and an active-low asynchronous reset.
package ocm_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] RAM_BASE = 12'h800;
  localparam logic [11:0] RAM_LAST = 12'hfff;
  localparam int unsigned RAM_WORDS = 2048;
  localparam int unsigned BLK_STRIDE_SH = 7;
  localparam logic [6:0] CHR_OFS = 7'h00;
  localparam logic [6:0] COL1_OFS = 7'h40;
  localparam logic [6:0] COL2A_OFS = 7'h28;
  localparam logic [6:0] COL2B_OFS = 7'h68;
  localparam logic [5:0] COL2_SPLIT = 6'h18;
  localparam logic [6:0] HOLE_LO = 7'h78;
  localparam logic [6:0] HOLE_HI = 7'h7a;
  localparam logic [5:0] CHARS_PER_BLK = 6'h28;
  localparam logic [16:0] FONT_BASE = 17'h10800;
  localparam logic [16:0] FONT_LAST = 17'h1567f;
  localparam logic [16:0] XFONT_BASE = 17'h18000;
  localparam logic [16:0] XFONT_LAST = 17'h1e43f;
  localparam logic [16:0] FONT_STRIDE = 17'h00028;
  localparam logic [16:0] XFONT_STRIDE = 17'h00034;
  localparam logic [8:0] FONT_CODES = 9'h140;
  localparam logic [5:0] XFONT_CODES = 6'h20;
  localparam logic [1:0] SKIP_PERIOD = 2'h3;
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned LINESEL_BIT = 6;
  localparam logic [15:0] TIME_MAX = 16'hffff;

  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } ocm_cpu_req_s;

  typedef struct packed {
    logic active;
    logic [3:0] block;
    logic [5:0] pos;
    logic [4:0] row;
    logic half_line;
    logic wide_skip;
    logic extra;
  } ocm_scan_s;

  typedef struct packed {
    logic valid;
    logic blank;
    logic [16:0] rom_addr;
    logic [7:0] col1;
    logic [7:0] col2;
  } ocm_fetch_s;
endpackage : ocm_pkg

// file: hdl/ocm_char_field.sv
// Overlay character RAM, font address former and interlace field flag.
// Assumes CPU requests and scan requests are on core_clk_i; sync pins are async.
`timescale 1ns/100ps
`default_nettype none
module ocm_char_field (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire ocm_pkg::ocm_cpu_req_s cpu_req_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_ack_o,
  input wire logic hsync_n_i,
  input wire logic vsync_n_i,
  input wire logic line_sel_i,
  output logic [7:0] polarity_rd_o,
  output logic field_odd_o,
  input wire ocm_pkg::ocm_scan_s scan_i,
  output ocm_pkg::ocm_fetch_s fetch_o,
  output logic dot_line_o
);

  ////////////////////////////////////////////////////////////////////////
  // Address helpers
  function automatic logic [11:0] blk_addr(input logic [3:0] blk, input logic [6:0] ofs);
    blk_addr = ocm_pkg::RAM_BASE | {1'b0, blk, ofs};
  endfunction : blk_addr

  function automatic logic in_ram(input logic [11:0] a);
    in_ram = (a >= ocm_pkg::RAM_BASE) && (a <= ocm_pkg::RAM_LAST);
  endfunction : in_ram

  ////////////////////////////////////////////////////////////////////////
  // Overlay RAM, dual port so scan never disturbs the CPU
  logic [7:0] ram [0:ocm_pkg::RAM_WORDS-1];
  logic [10:0] cpu_idx;
  logic cpu_hit;
  logic [7:0] cpu_rdata;
  logic cpu_ack;
  logic [7:0] next_cpu_rdata;
  logic next_cpu_ack;

  assign cpu_idx = cpu_req_i.addr[10:0];
  assign cpu_hit = cpu_req_i.req && in_ram(cpu_req_i.addr);

  always_ff @(posedge core_clk_i) begin
    if (cpu_hit && cpu_req_i.wr) begin
      ram[cpu_idx] <= cpu_req_i.wdata;
    end
  end

  always_comb begin
    next_cpu_ack = cpu_req_i.req;
    next_cpu_rdata = cpu_rdata;
    if (cpu_req_i.req && !cpu_req_i.wr) begin
      // Outside the window reads zero; holes 78..7A are plain cells here
      next_cpu_rdata = cpu_hit ? ram[cpu_idx] : 8'h00;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_rdata <= 8'h00;
      cpu_ack <= 1'b0;
    end else begin
      cpu_rdata <= next_cpu_rdata;
      cpu_ack <= next_cpu_ack;
    end
  end

  assign cpu_rdata_o = cpu_rdata;
  assign cpu_ack_o = cpu_ack;

  ////////////////////////////////////////////////////////////////////////
  // Sync inputs: three stages, edge once stages two and three agree
  logic [2:0] hs_sync;
  logic [2:0] vs_sync;
  logic hs_state;
  logic vs_state;
  logic [2:0] next_hs_sync;
  logic [2:0] next_vs_sync;
  logic next_hs_state;
  logic next_vs_state;
  logic hs_fall;
  logic vs_fall;
  logic vs_rise;

  always_comb begin
    next_hs_sync = {hs_sync[1:0], hsync_n_i};
    next_vs_sync = {vs_sync[1:0], vsync_n_i};
    next_hs_state = (hs_sync[1] == hs_sync[2]) ? hs_sync[2] : hs_state;
    next_vs_state = (vs_sync[1] == vs_sync[2]) ? vs_sync[2] : vs_state;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_sync <= 3'h7;
      vs_sync <= 3'h7;
      hs_state <= 1'b1;
      vs_state <= 1'b1;
    end else begin
      hs_sync <= next_hs_sync;
      vs_sync <= next_vs_sync;
      hs_state <= next_hs_state;
      vs_state <= next_vs_state;
    end
  end

  // Negative polarity: falling pin edge is the sync start
  assign hs_fall = hs_state && !next_hs_state;
  assign vs_fall = vs_state && !next_vs_state;
  assign vs_rise = !vs_state && next_vs_state;

  ////////////////////////////////////////////////////////////////////////
  // Field determination
  logic [15:0] since_hs;
  logic [15:0] prev_time;
  logic pend_odd;
  logic field_odd;
  logic [15:0] next_since_hs;
  logic [15:0] next_prev_time;
  logic next_pend_odd;
  logic next_field_odd;

  always_comb begin
    next_since_hs = since_hs;
    next_prev_time = prev_time;
    next_pend_odd = pend_odd;
    next_field_odd = field_odd;
    if (hs_fall) begin
      next_since_hs = 16'h0000;
    end else if (since_hs != ocm_pkg::TIME_MAX) begin
      next_since_hs = since_hs + 16'h0001; // Saturates, no wrap
    end
    if (vs_fall) begin
      next_pend_odd = (since_hs < prev_time);
      next_prev_time = since_hs;
    end
    if (vs_rise) begin
      next_field_odd = pend_odd;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_hs <= 16'h0000;
      prev_time <= 16'h0000;
      pend_odd <= 1'b0;
      field_odd <= 1'b0;
    end else begin
      since_hs <= next_since_hs;
      prev_time <= next_prev_time;
      pend_odd <= next_pend_odd;
      field_odd <= next_field_odd;
    end
  end

  // Flag ignores the select bit; correct only with PWM bit 0 cleared
  always_comb begin
    polarity_rd_o = 8'h00;
    polarity_rd_o[ocm_pkg::FLAG_BIT] = field_odd;
    polarity_rd_o[ocm_pkg::LINESEL_BIT] = line_sel_i;
  end
  assign field_odd_o = field_odd;

  ////////////////////////////////////////////////////////////////////////
  // Scan fetch: one request per cycle, answer one cycle later
  logic [11:0] chr_a;
  logic [11:0] c1_a;
  logic [11:0] c2_a;
  logic [8:0] code;
  logic [4:0] xcode;
  logic skipped;
  logic row_bit;
  logic [16:0] font_a;
  ocm_pkg::ocm_fetch_s fetch;
  ocm_pkg::ocm_fetch_s next_fetch;
  logic dot_line;
  logic next_dot_line;
  logic [5:0] pos1;

  always_comb begin
    chr_a = blk_addr(scan_i.block, ocm_pkg::CHR_OFS + {1'b0, scan_i.pos});
    c1_a = blk_addr(scan_i.block, ocm_pkg::COL1_OFS + {1'b0, scan_i.pos});
    if (scan_i.pos < ocm_pkg::COL2_SPLIT) begin
      c2_a = blk_addr(scan_i.block, ocm_pkg::COL2A_OFS + {1'b0, scan_i.pos});
    end else begin
      c2_a = blk_addr(scan_i.block,
                      ocm_pkg::COL2B_OFS + {1'b0, scan_i.pos - ocm_pkg::COL2_SPLIT});
    end
  end

  assign pos1 = scan_i.pos + 6'h01;
  // Position n counts from 1; 3n positions drop only in wide dot blocks
  assign skipped = scan_i.wide_skip && ((pos1 % 6'(ocm_pkg::SKIP_PERIOD)) == 6'h00);
  // Select low: even field dot line 1, odd field dot line 0
  assign row_bit = line_sel_i ^ !field_odd;

  always_comb begin
    code = {ram[c2_a[10:0]][ocm_pkg::FLAG_BIT], ram[chr_a[10:0]]};
    xcode = ram[c1_a[10:0]][4:0];
    if (scan_i.extra) begin
      font_a = ocm_pkg::XFONT_BASE + 17'(xcode) * ocm_pkg::XFONT_STRIDE
               + 17'(scan_i.row);
    end else begin
      font_a = ocm_pkg::FONT_BASE + 17'(code) * ocm_pkg::FONT_STRIDE
               + 17'(scan_i.row);
    end
  end

  always_comb begin
    next_fetch = fetch;
    next_fetch.valid = scan_i.active && (scan_i.pos < ocm_pkg::CHARS_PER_BLK);
    next_dot_line = dot_line;
    if (next_fetch.valid) begin
      next_fetch.rom_addr = font_a;
      next_fetch.col1 = ram[c1_a[10:0]];
      next_fetch.col2 = ram[c2_a[10:0]];
      // Codes beyond the stored fonts, or skipped cells, show blank
      next_fetch.blank = skipped || (!scan_i.extra && code >= ocm_pkg::FONT_CODES)
                         || (font_a > ocm_pkg::XFONT_LAST);
      next_dot_line = scan_i.half_line ? row_bit : 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch <= '0;
      dot_line <= 1'b0;
    end else begin
      fetch <= next_fetch;
      dot_line <= next_dot_line;
    end
  end

  assign fetch_o = fetch;
  assign dot_line_o = dot_line;

endmodule : ocm_char_field
`default_nettype wire

// file: verification/ocm_char_field_properties.sv
// Port checker for the overlay character block.
// Assumes one clock and an active-low async reset; bound from the bench.
`timescale 1ns/100ps
`default_nettype none
module ocm_char_field_properties (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire ocm_pkg::ocm_cpu_req_s cpu_req_i,
  input wire logic [7:0] cpu_rdata_o,
  input wire logic cpu_ack_o,
  input wire logic vsync_n_i,
  input wire logic line_sel_i,
  input wire logic [7:0] polarity_rd_o,
  input wire logic field_odd_o,
  input wire ocm_pkg::ocm_scan_s scan_i,
  input wire ocm_pkg::ocm_fetch_s fetch_o,
  input wire logic dot_line_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] vs_age;
  logic [3:0] next_vs_age;
  logic vs_q;
  // Cycles since the sync pin rose, saturating
  always_comb begin
    next_vs_age = (vsync_n_i && !vs_q) ? 4'h0 : vs_age + {3'h0, vs_age != 4'hf};
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vs_age <= 4'hf;
      vs_q <= 1'b1;
    end else begin
      vs_age <= next_vs_age;
      vs_q <= vsync_n_i;
    end
  end
  chk_ack_next: assert property (cpu_req_i.req |=> cpu_ack_o) else $error("no ack");
  chk_unmapped_zero: assert property (cpu_req_i.req && !cpu_req_i.wr &&
    cpu_req_i.addr < 12'h800 |=> cpu_rdata_o == 8'h00) else $error("unmapped read");
  chk_flag_bit: assert property (polarity_rd_o[7] == field_odd_o) else $error("bit 7");
  chk_flag_vsrise: assert property ($changed(field_odd_o) |-> vs_age <= 4'ha)
    else $error("flag moved off sync rise");
  chk_fetch_next: assert property (scan_i.active && scan_i.pos < 6'h28 |=> fetch_o.valid)
    else $error("no fetch");
  chk_skip_blank: assert property (scan_i.active && scan_i.wide_skip &&
    scan_i.pos < 6'h28 && scan_i.pos % 3 == 2 |=> fetch_o.blank) else $error("no skip");
  chk_font_range: assert property (fetch_o.valid && !fetch_o.blank |->
    fetch_o.rom_addr inside {[17'h10800:17'h1567f], [17'h18000:17'h1e43f]})
    else $error("rom address out of range");
  chk_dot_line: assert property (scan_i.active && scan_i.half_line &&
    scan_i.pos < 6'h28 |=>
    dot_line_o == ($past(line_sel_i) ^ !$past(field_odd_o))) else $error("dot line");
  cover property (cpu_ack_o);
  cover property ($rose(field_odd_o));
  cover property (fetch_o.valid && fetch_o.blank);
endmodule : ocm_char_field_properties
`default_nettype wire

// file: verification/ocm_cpu_model.sv
// CPU core model: single byte accesses with an idle cycle between.
// Assumes the ack comes one cycle after each request.
`timescale 1ns/100ps
`default_nettype none
module ocm_cpu_model (
  input wire logic core_clk_i,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  output var ocm_pkg::ocm_cpu_req_s req_o
);
  initial req_o = '0;
  // Bytes only; base plus 78..7a is never addressed
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic ok, output logic [7:0] q);
    @(negedge core_clk_i);
    req_o = '{1'b1, w, a, d};
    @(negedge core_clk_i);
    ok = ack_i;
    q = rdata_i;
    // Released lines flip so a stale value cannot pass
    req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask : acc
endmodule : ocm_cpu_model
`default_nettype wire

// file: verification/ocm_char_field_tb_top.sv
// Bench for the overlay character block, driven through a CPU model.
// Assumes the package and design are compiled first.
`timescale 1ns/100ps
`default_nettype none
module ocm_char_field_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hs = 1'b1;
  logic vs = 1'b1;
  logic sel = 1'b0;
  logic ack, odd, dl, ok;
  logic [7:0] rd, pol, q;
  ocm_pkg::ocm_cpu_req_s req;
  ocm_pkg::ocm_scan_s sc = '0;
  ocm_pkg::ocm_fetch_s f;
  int n_mismatch = 0;
  int checks = 0;
  ocm_char_field ocm_char_field_i (.core_clk_i, .rst_n_i, .cpu_req_i(req), .cpu_rdata_o(rd),
    .cpu_ack_o(ack), .hsync_n_i(hs), .vsync_n_i(vs), .line_sel_i(sel), .polarity_rd_o(pol),
    .field_odd_o(odd), .scan_i(sc), .fetch_o(f), .dot_line_o(dl));
  ocm_cpu_model ocm_cpu_model_i (.core_clk_i, .ack_i(ack), .rdata_i(rd), .req_o(req));
  initial forever #50 core_clk_i = ~core_clk_i;
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    ocm_cpu_model_i.acc(w, a, d, ok, q);
    cmp("ack", 1, ok);
    if (!w) cmp("rdata", d, q);
  endtask : bus
  task automatic scan(input logic [3:0] b, input logic [5:0] p, input logic [4:0] r,
    input logic w, input logic x, input logic h);
    @(negedge core_clk_i);
    sc = '{1'b1, b, p, r, h, w, x};
    @(negedge core_clk_i);
    sc = '0;
    cmp("valid", 1, f.valid);
  endtask : scan
  task automatic t_ram;
    bus(1'b1, 12'h800, 8'h5a);
    bus(1'b1, 12'h400, 8'h77);
    bus(1'b1, 12'hfff, 8'ha5);
    bus(1'b0, 12'h800, 8'h5a);
    bus(1'b0, 12'hfff, 8'ha5);
    bus(1'b0, 12'h400, 8'h00);
  endtask : t_ram
  // Every position of the top block, wide and narrow dots
  task automatic t_grid;
    logic [11:0] c2;
    for (int p = 0; p < 40; p++) begin
      c2 = (p < 24) ? 12'hfa8 + 12'(p) : 12'hfe8 + 12'(p - 24);
      bus(1'b1, 12'hf80 + 12'(p), 8'(p));
      bus(1'b1, 12'hfc0 + 12'(p), 8'(p + 64));
      bus(1'b1, c2, 8'h00);
      scan(4'hf, 6'(p), 5'h3, 1'b1, 1'b0, 1'b0);
      cmp("wide blank", p % 3 == 2, f.blank);
      scan(4'hf, 6'(p), 5'h3, 1'b0, 1'b0, 1'b0);
      cmp("narrow blank", 0, f.blank);
      cmp("rom", 17'h10800 + 17'(p * 40 + 3), f.rom_addr);
      cmp("col1", p + 64, f.col1);
    end
  endtask : t_grid
  task automatic t_code;
    bus(1'b1, 12'h898, 8'h3f);
    bus(1'b1, 12'h8e8, 8'h81);
    bus(1'b1, 12'h8d8, 8'h1f);
    scan(4'h1, 6'd24, 5'h13, 1'b0, 1'b0, 1'b0);
    cmp("rom", 17'h10800 + 17'd319 * 17'd40 + 17'd19, f.rom_addr);
    cmp("col2", 8'h81, f.col2);
    scan(4'h1, 6'd24, 5'h19, 1'b0, 1'b1, 1'b0);
    cmp("xrom", 17'h18000 + 17'd31 * 17'd52 + 17'd25, f.rom_addr);
    bus(1'b1, 12'h898, 8'h40);
    scan(4'h1, 6'd24, 5'h0, 1'b0, 1'b0, 1'b0);
    cmp("code 320 blank", 1, f.blank);
  endtask : t_code
  task automatic field(input int n, input logic e, input logic was);
    @(negedge core_clk_i);
    hs = 1'b0;
    // Pin filter drops one-cycle pulses, so hold the sync low longer
    repeat (4) @(negedge core_clk_i);
    hs = 1'b1;
    repeat (n) @(negedge core_clk_i);
    vs = 1'b0;
    repeat (8) @(negedge core_clk_i);
    cmp("flag before rise", was, odd);
    vs = 1'b1;
    repeat (8) @(negedge core_clk_i);
    cmp("flag", e, odd);
    cmp("bit7", e, pol[7]);
    scan(4'hf, 6'd0, 5'h0, 1'b0, 1'b0, 1'b1);
    cmp("dot line", sel ^ !e, dl);
    sel = ~sel;
    scan(4'hf, 6'd0, 5'h0, 1'b0, 1'b0, 1'b1);
    cmp("dot line flipped", sel ^ !e, dl);
    cmp("bit6", sel, pol[6]);
  endtask : field
  // Flag only trusted with the PWM mode bit cleared
  task automatic t_field;
    field(40, 1'b0, 1'b0);
    field(20, 1'b1, 1'b0);
    field(30, 1'b0, 1'b1);
  endtask : t_field
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_ram;
    t_grid;
    t_code;
    t_field;
    test_done;
  end
endmodule : ocm_char_field_tb_top
bind ocm_char_field ocm_char_field_properties ocm_char_field_properties_i (.core_clk_i,
  .rst_n_i, .cpu_req_i, .cpu_rdata_o, .cpu_ack_o, .vsync_n_i, .line_sel_i, .polarity_rd_o,
  .field_odd_o, .scan_i, .fetch_o, .dot_line_o);
`default_nettype wire
